/* File: eec_mem_model.sv */
// Memory-side model: gate table and stack words, with a log of the first 16 completed accesses
`timescale 1ns/100ps
module eec_mem_model
  import eec_pkg::*;
(
  input wire logic aclk,
  input wire logic slow,
  input eec_mem_req_s mem_req,
  output logic mem_ready,
  output logic [63:0] mem_rdata
);
  logic [63:0] mem [0:63];
  logic [63:0] log_addr [0:15];
  logic [63:0] log_data [0:15];
  logic [3:0] log_bytes [0:15];
  int n = 0;
  logic tick = 1'b0;
  // Slow mode accepts only every second cycle, so requests must stand
  assign mem_ready = mem_req.valid && (!slow || tick);
  // Idle read data toggles so a stale sample never looks valid
  assign mem_rdata = (mem_req.valid && !mem_req.we) ? mem[mem_req.addr[8:3]] : {32{tick, !tick}};
  always @(posedge aclk) begin
    tick <= !tick;
    if (mem_ready && n < 16) begin
      log_addr[n] <= mem_req.addr;
      log_data[n] <= mem_req.wdata;
      log_bytes[n] <= mem_req.bytes;
      n <= n + 1;
      if (mem_req.we) begin
        mem[mem_req.addr[8:3]] <= mem_req.wdata;
      end
    end
  end
endmodule : eec_mem_model

/* File: eec_pkg.sv */
// Constants, types and state codes of the exception entry and return unit
package eec_pkg;
//==========================================================
// Behaviour
// - Error code bit 0 set when an event outside the program caused it.
// - Bit 1 set when the index names a gate table entry, else clear.
// - Bit 2 meaningful only with bit 1 clear: set local, clear global table.
// - Selector index sits above the flags; upper half is reserved zero.
// - Error code is all zero for no segment or a null descriptor.
// - With long mode inactive pushes are word or doubleword by gate size.
// - Interrupt return never pops the error code; software removes it.
// - No error code for pin, local pin or software interrupt events.
// - In 64-bit mode every frame push is an 8-byte zero-extended store.
// - 64-bit mode always pushes stack selector and pointer; legacy only on privilege change.
// - 64-bit delivery with privilege change makes the new stack selector null.
// - In 64-bit mode gates are 16 bytes with a 64-bit target offset.
// - 64-bit gate offset in the table is the vector times 16.
// - Gate type is bits 11:8, stack table index bits 4:0 of bytes 7:4.
// - Target upper half from bytes 11:8; non-canonical target faults.
// - Target code segment must be 64-bit, else fault reporting the vector.
// - In extended mode types 0EH and 0FH are 64-bit interrupt and trap gates.
// - In extended mode 16-bit gate types 06H and 07H fault with zero code.
// - With long mode active the stack pointer aligns down to 16 bytes.
// - Return pops 8-byte items for 64-bit operand size; adjust follows stack size.
// - Return pops stack selector and pointer always in 64-bit mode, else on change.
// - Return accepts a null stack selector for 64-bit target below privilege 3.
// - 64-bit frame order: stack selector, pointer, flags, code selector, pointer.
// - An error code is pushed last, after the saved instruction pointer.
//==========================================================
// Register offsets
localparam logic [7:0] OFF_CTRL = 8'h00;
localparam logic [7:0] OFF_EVENT = 8'h04;
localparam logic [7:0] OFF_IDT = 8'h08;
localparam logic [7:0] OFF_SP_LO = 8'h0C;
localparam logic [7:0] OFF_SP_HI = 8'h10;
localparam logic [7:0] OFF_SEL = 8'h14;
localparam logic [7:0] OFF_FLAGS = 8'h18;
localparam logic [7:0] OFF_IP_LO = 8'h1C;
localparam logic [7:0] OFF_IP_HI = 8'h20;
localparam logic [7:0] OFF_STATUS = 8'h24;
localparam logic [7:0] OFF_ERRCODE = 8'h28;
localparam logic [7:0] OFF_TSP_LO = 8'h2C;
localparam logic [7:0] OFF_TSP_HI = 8'h30;
localparam logic [31:0] RST_ZERO = 32'h0000_0000;
// Control fields
localparam int C_GO_DEL = 0;
localparam int C_GO_RET = 1;
localparam int C_LMA = 2;
localparam int C_M64 = 3;
localparam int C_CPL = 4;
localparam int C_TCPL = 6;
localparam int C_CSL = 8;
localparam int C_CSD = 9;
localparam int C_OPS64 = 10;
localparam int C_STK64 = 11;
localparam logic [31:0] CTRL_GO_MASK = 32'h0000_0003;
// Event fields
localparam int E_VEC = 0;
localparam int E_SRC = 8;
localparam int E_HASEC = 11;
localparam int E_SEGREF = 12;
localparam int E_TBL = 13;
localparam int E_NULL = 15;
localparam int E_IDX = 16;
localparam logic [2:0] SRC_PROG = 3'h0;
localparam logic [2:0] SRC_EXT = 3'h1;
localparam logic [2:0] SRC_MASKABLE_INTERRUPT_PIN = 3'h2;
localparam logic [2:0] SRC_LINT = 3'h3;
localparam logic [2:0] SRC_SWI = 3'h4;
localparam logic [1:0] TBL_LDT = 2'h1;
localparam logic [1:0] TBL_IDT = 2'h2;
// Gate fields and types
localparam int G_TYPE = 40;
localparam int G_IST = 32;
localparam logic [3:0] GT_INT16 = 4'h6;
localparam logic [3:0] GT_TRAP16 = 4'h7;
localparam logic [3:0] GT_INT = 4'hE;
localparam logic [3:0] GT_TRAP = 4'hF;
localparam logic [3:0] SLOT64 = 4'h8;
localparam logic [3:0] SLOT32 = 4'h4;
localparam logic [3:0] SLOT16 = 4'h2;
localparam logic [63:0] ALIGN16 = 64'hFFFF_FFFF_FFFF_FFF0;
// Status fields
localparam int S_BUSY = 0;
localparam int S_DONE = 1;
localparam int S_GP = 2;
localparam int S_SSLD = 3;
localparam int S_IST = 8;
localparam int S_TYPE = 16;
localparam logic [1:0] RESP_OKAY = 2'h0;
localparam logic [1:0] RESP_DECERR = 2'h3;
typedef enum logic [2:0] {
  ST_IDLE = 3'b000,
  ST_F0 = 3'b001,
  ST_F1 = 3'b010,
  ST_CHK = 3'b011,
  ST_PUSH = 3'b100,
  ST_POP = 3'b101,
  ST_RCHK = 3'b110
} eec_state_e;
typedef struct packed {
  logic valid;
  logic we;
  logic [63:0] addr;
  logic [63:0] wdata;
  logic [3:0] bytes;
} eec_mem_req_s;
endpackage : eec_pkg

/* File: eec_unit.sv */
// Exception entry and return unit with AXI4-Lite control registers
//
// The AXI4-Lite register port and the address map are this design's own decisions.
`timescale 1ns/100ps
module eec_unit
  import eec_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_awaddr,
  input wire logic s_awvalid,
  output logic s_awready,
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  input wire logic s_wvalid,
  output logic s_wready,
  output logic [1:0] s_bresp,
  output logic s_bvalid,
  input wire logic s_bready,
  input wire logic [7:0] s_araddr,
  input wire logic s_arvalid,
  output logic s_arready,
  output logic [31:0] s_rdata,
  output logic [1:0] s_rresp,
  output logic s_rvalid,
  input wire logic s_rready,
  output eec_mem_req_s mem_req,
  input wire logic mem_ready,
  input wire logic [63:0] mem_rdata
);
  logic [31:0] ctrl, event_r, idt_base, flags, errcode;
  logic [63:0] sp, tss_sp, ip, g0, g1, ptr, pop_ip, pop_sp;
  logic [15:0] ss_sel, cs_sel, pop_cs, pop_ss;
  logic [31:0] pop_fl;
  logic [2:0] idx;
  logic done_f, gp_f, ssld_f;
  eec_state_e state;
  logic aw_hold, w_hold;
  logic [7:0] aw_a;
  logic [31:0] w_d;
  logic [3:0] w_s;
  logic wr_fire, cfg_wr, go_del, go_ret;
  logic long_mode_active, m64, cpl_chg, quiet, external_event, fault, canon, pops, ss_fault;
  logic [1:0] cur_cpl, tgt_cpl;
  logic [7:0] vec;
  logic [2:0] src;
  logic [3:0] gtype, pw, popw;
  logic [31:0] seg_ec, vec_ec, fault_ec;
  logic [63:0] gate_ip, gate_addr, stk_base;
  logic [5:0] en;
  logic [4:0] pen;

  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] d, input logic [3:0] s);
    logic [31:0] r;
    r = o;
    for (int b = 0; b < 4; b++) begin
      if (s[b]) begin
        r[b*8 +: 8] = d[b*8 +: 8];
      end
    end
    return r;
  endfunction : merge

  //==========================================================
  // AXI4-Lite slave
  assign s_awready = !aw_hold;
  assign s_wready = !w_hold;
  assign s_arready = !s_rvalid;
  assign wr_fire = aw_hold && w_hold && !s_bvalid;
  // Configuration stays frozen while an operation runs
  assign cfg_wr = wr_fire && state == ST_IDLE;
  assign go_del = cfg_wr && aw_a == OFF_CTRL && w_s[0] && w_d[C_GO_DEL];
  assign go_ret = cfg_wr && aw_a == OFF_CTRL && w_s[0] && w_d[C_GO_RET] && !w_d[C_GO_DEL];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold <= 1'b0;
      w_hold <= 1'b0;
      aw_a <= 8'h00;
      w_d <= RST_ZERO;
      w_s <= 4'h0;
      s_bvalid <= 1'b0;
      s_bresp <= RESP_OKAY;
    end else begin
      if (s_awvalid && !aw_hold) begin
        aw_hold <= 1'b1;
        aw_a <= s_awaddr;
      end
      if (s_wvalid && !w_hold) begin
        w_hold <= 1'b1;
        w_d <= s_wdata;
        w_s <= s_wstrb;
      end
      if (wr_fire) begin
        aw_hold <= 1'b0;
        w_hold <= 1'b0;
        s_bvalid <= 1'b1;
        s_bresp <= (aw_a[1:0] == 2'h0 && aw_a <= OFF_TSP_HI) ? RESP_OKAY : RESP_DECERR;
      end else if (s_bready) begin
        s_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_rvalid <= 1'b0;
      s_rdata <= RST_ZERO;
      s_rresp <= RESP_OKAY;
    end else if (s_arvalid && !s_rvalid) begin
      s_rvalid <= 1'b1;
      s_rresp <= RESP_OKAY;
      case (s_araddr)
        OFF_CTRL: s_rdata <= ctrl;
        OFF_EVENT: s_rdata <= event_r;
        OFF_IDT: s_rdata <= idt_base;
        OFF_SP_LO: s_rdata <= sp[31:0];
        OFF_SP_HI: s_rdata <= sp[63:32];
        OFF_SEL: s_rdata <= {cs_sel, ss_sel};
        OFF_FLAGS: s_rdata <= flags;
        OFF_IP_LO: s_rdata <= ip[31:0];
        OFF_IP_HI: s_rdata <= ip[63:32];
        OFF_STATUS: s_rdata <= {12'h000, gtype, 3'h0, g0[G_IST +: 5], 4'h0, ssld_f, gp_f, done_f, state != ST_IDLE};
        OFF_ERRCODE: s_rdata <= errcode;
        OFF_TSP_LO: s_rdata <= tss_sp[31:0];
        OFF_TSP_HI: s_rdata <= tss_sp[63:32];
        default: begin
          s_rdata <= RST_ZERO;
          s_rresp <= RESP_DECERR;
        end
      endcase
    end else if (s_rready) begin
      s_rvalid <= 1'b0;
    end
  end

  //==========================================================
  // Configuration registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl <= RST_ZERO;
      event_r <= RST_ZERO;
      idt_base <= RST_ZERO;
      tss_sp <= {RST_ZERO, RST_ZERO};
    end else if (cfg_wr) begin
      case (aw_a)
        OFF_CTRL: ctrl <= merge(ctrl, w_d, w_s) & ~CTRL_GO_MASK;
        OFF_EVENT: event_r <= merge(event_r, w_d, w_s);
        OFF_IDT: idt_base <= merge(idt_base, w_d, w_s);
        OFF_TSP_LO: tss_sp[31:0] <= merge(tss_sp[31:0], w_d, w_s);
        OFF_TSP_HI: tss_sp[63:32] <= merge(tss_sp[63:32], w_d, w_s);
        default: ;
      endcase
    end
  end

  //==========================================================
  // Decode of event, gate and frame layout
  assign long_mode_active = ctrl[C_LMA];
  assign m64 = ctrl[C_M64] && long_mode_active;
  assign cur_cpl = ctrl[C_CPL +: 2];
  assign tgt_cpl = ctrl[C_TCPL +: 2];
  assign cpl_chg = tgt_cpl < cur_cpl;
  assign vec = event_r[E_VEC +: 8];
  assign src = event_r[E_SRC +: 3];
  assign quiet = src == SRC_MASKABLE_INTERRUPT_PIN || src == SRC_LINT || src == SRC_SWI;
  assign external_event = src == SRC_EXT || src == SRC_MASKABLE_INTERRUPT_PIN || src == SRC_LINT;
  // Index above three flags, upper half reserved zero
  assign seg_ec = (!event_r[E_SEGREF] || event_r[E_NULL]) ? RST_ZERO :
    {16'h0000, event_r[E_IDX +: 13],
     event_r[E_TBL +: 2] != TBL_IDT && event_r[E_TBL +: 2] == TBL_LDT,
     event_r[E_TBL +: 2] == TBL_IDT, external_event};
  assign vec_ec = {16'h0000, 5'h00, vec, 1'b0, 1'b1, external_event};
  assign gtype = g0[G_TYPE +: 4];
  assign gate_ip = {long_mode_active ? g1[31:0] : RST_ZERO, g0[63:48], g0[15:0]};
  assign canon = (&gate_ip[63:47]) || !(|gate_ip[63:47]);
  // Extended mode gates are 16 bytes, legacy ones 8
  assign gate_addr = {RST_ZERO, idt_base} + (long_mode_active ? {52'h0, vec, 4'h0} : {53'h0, vec, 3'h0});
  assign pw = long_mode_active ? SLOT64 : (gtype[3] ? SLOT32 : SLOT16);
  assign popw = ctrl[C_OPS64] ? SLOT64 : SLOT32;
  assign stk_base = long_mode_active ? ((cpl_chg ? tss_sp : sp) & ALIGN16) : (cpl_chg ? tss_sp : sp);
  assign en = {event_r[E_HASEC] && !quiet, 3'b111, {2{m64 || cpl_chg}}};
  assign pops = m64 || pop_cs[1:0] != cur_cpl;
  assign pen = {{2{pops}}, 3'b111};
  assign ss_fault = pop_ss[15:2] == 14'h0 && !(ctrl[C_CSL] && pop_cs[1:0] != 2'h3);

  always_comb begin
    fault = 1'b0;
    fault_ec = RST_ZERO;
    if (long_mode_active) begin
      if (gtype == GT_INT16 || gtype == GT_TRAP16) begin
        fault = 1'b1;
      end else if (gtype != GT_INT && gtype != GT_TRAP) begin
        fault = 1'b1;
      end else if (!canon) begin
        fault = 1'b1;
      end else if (!ctrl[C_CSL] || ctrl[C_CSD]) begin
        fault = 1'b1;
        fault_ec = vec_ec;
      end
    end else if (gtype != GT_INT16 && gtype != GT_TRAP16 && gtype != GT_INT && gtype != GT_TRAP) begin
      fault = 1'b1;
    end
  end

  //==========================================================
  // Memory request; held stable by the sequencer until ready
  always_comb begin
    mem_req = '0;
    case (state)
      ST_F0: begin
        mem_req.valid = 1'b1;
        mem_req.addr = gate_addr;
        mem_req.bytes = SLOT64;
      end
      ST_F1: begin
        mem_req.valid = 1'b1;
        mem_req.addr = gate_addr + 64'h8;
        mem_req.bytes = SLOT64;
      end
      ST_PUSH: begin
        if (idx < 3'd6 && en[idx]) begin
          mem_req.valid = 1'b1;
          mem_req.we = 1'b1;
          mem_req.addr = ptr - {60'h0, pw};
          mem_req.bytes = pw;
          case (idx)
            3'd0: mem_req.wdata = {48'h0, ss_sel};
            3'd1: mem_req.wdata = sp;
            3'd2: mem_req.wdata = {RST_ZERO, flags};
            3'd3: mem_req.wdata = {48'h0, cs_sel};
            3'd4: mem_req.wdata = ip;
            default: mem_req.wdata = {RST_ZERO, errcode};
          endcase
        end
      end
      ST_POP: begin
        if (idx < 3'd5 && pen[idx]) begin
          mem_req.valid = 1'b1;
          mem_req.addr = ptr;
          mem_req.bytes = popw;
        end
      end
      default: ;
    endcase
  end

  //==========================================================
  // Sequencer
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= ST_IDLE;
      idx <= 3'h0;
      ptr <= {RST_ZERO, RST_ZERO};
      g0 <= {RST_ZERO, RST_ZERO};
      g1 <= {RST_ZERO, RST_ZERO};
    end else begin
      case (state)
        ST_IDLE: begin
          idx <= 3'h0;
          if (go_del) begin
            state <= ST_F0;
          end else if (go_ret) begin
            ptr <= sp;
            state <= ST_POP;
          end
        end
        ST_F0: begin
          if (mem_ready) begin
            g0 <= mem_rdata;
            g1 <= {RST_ZERO, RST_ZERO};
            state <= long_mode_active ? ST_F1 : ST_CHK;
          end
        end
        ST_F1: begin
          if (mem_ready) begin
            g1 <= mem_rdata;
            state <= ST_CHK;
          end
        end
        ST_CHK: begin
          if (fault) begin
            state <= ST_IDLE;
          end else begin
            ptr <= stk_base;
            state <= ST_PUSH;
          end
        end
        ST_PUSH: begin
          if (idx == 3'd6) begin
            state <= ST_IDLE;
          end else if (!en[idx]) begin
            idx <= idx + 3'd1;
          end else if (mem_ready) begin
            ptr <= ptr - {60'h0, pw};
            idx <= idx + 3'd1;
          end
        end
        ST_POP: begin
          if (idx == 3'd5) begin
            state <= ST_RCHK;
          end else if (!pen[idx]) begin
            idx <= idx + 3'd1;
          end else if (mem_ready) begin
            ptr <= ptr + {60'h0, popw};
            idx <= idx + 3'd1;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // Popped items, narrowed to the operand size
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pop_ip <= {RST_ZERO, RST_ZERO};
      pop_sp <= {RST_ZERO, RST_ZERO};
      pop_cs <= 16'h0000;
      pop_ss <= 16'h0000;
      pop_fl <= RST_ZERO;
    end else if (state == ST_POP && idx < 3'd5 && pen[idx] && mem_ready) begin
      case (idx)
        3'd0: pop_ip <= ctrl[C_OPS64] ? mem_rdata : {RST_ZERO, mem_rdata[31:0]};
        3'd1: pop_cs <= mem_rdata[15:0];
        3'd2: pop_fl <= mem_rdata[31:0];
        3'd3: pop_sp <= ctrl[C_OPS64] ? mem_rdata : {RST_ZERO, mem_rdata[31:0]};
        default: pop_ss <= mem_rdata[15:0];
      endcase
    end
  end

  //==========================================================
  // Architectural state: software when idle, hardware at commit
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sp <= {RST_ZERO, RST_ZERO};
      ip <= {RST_ZERO, RST_ZERO};
      ss_sel <= 16'h0000;
      cs_sel <= 16'h0000;
      flags <= RST_ZERO;
    end else if (state == ST_PUSH && idx == 3'd6) begin
      sp <= ptr;
      ip <= gate_ip;
      cs_sel <= g0[31:16];
      if (m64 && cpl_chg) begin
        ss_sel <= {14'h0, tgt_cpl};
      end
    end else if (state == ST_RCHK && !(pops && ss_fault)) begin
      ip <= pop_ip;
      cs_sel <= pop_cs;
      flags <= pop_fl;
      if (pops) begin
        sp <= pop_sp;
        ss_sel <= pop_ss;
      end else begin
        sp <= ctrl[C_STK64] ? ptr : {sp[63:32], ptr[31:0]};
      end
    end else if (cfg_wr) begin
      case (aw_a)
        OFF_SP_LO: sp[31:0] <= merge(sp[31:0], w_d, w_s);
        OFF_SP_HI: sp[63:32] <= merge(sp[63:32], w_d, w_s);
        OFF_IP_LO: ip[31:0] <= merge(ip[31:0], w_d, w_s);
        OFF_IP_HI: ip[63:32] <= merge(ip[63:32], w_d, w_s);
        OFF_FLAGS: flags <= merge(flags, w_d, w_s);
        OFF_SEL: {cs_sel, ss_sel} <= merge({cs_sel, ss_sel}, w_d, w_s);
        default: ;
      endcase
    end
  end

  // Outcome flags; a start only happens when idle, so set never meets clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      done_f <= 1'b0;
      gp_f <= 1'b0;
      ssld_f <= 1'b0;
      errcode <= RST_ZERO;
    end else if (go_del || go_ret) begin
      done_f <= 1'b0;
      gp_f <= 1'b0;
      ssld_f <= 1'b0;
    end else if (state == ST_CHK) begin
      errcode <= fault ? fault_ec : seg_ec;
      gp_f <= fault;
      done_f <= fault;
    end else if (state == ST_PUSH && idx == 3'd6) begin
      done_f <= 1'b1;
    end else if (state == ST_RCHK) begin
      done_f <= 1'b1;
      gp_f <= pops && ss_fault;
      ssld_f <= pops && !ss_fault && pop_ss[15:2] != 14'h0;
      if (pops && ss_fault) begin
        errcode <= RST_ZERO;
      end
    end
  end

  //==========================================================
  // Assertions
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_gate_addr;
    (state == ST_F1) |-> mem_req.addr == {RST_ZERO, idt_base} + {52'h0, vec, 4'h0} + 64'h8;
  endproperty
  a_gate_addr: assert property (p_gate_addr) else $error("gate address not vector times 16");

  property p_slot8;
    (state == ST_PUSH && mem_req.we && long_mode_active) |-> mem_req.bytes == 4'h8 && mem_req.addr[2:0] == 3'h0;
  endproperty
  a_slot8: assert property (p_slot8) else $error("frame push not 8 bytes");

  property p_align;
    (state == ST_CHK && !fault && long_mode_active) |=> ptr[3:0] == 4'h0;
  endproperty
  a_align: assert property (p_align) else $error("frame base not 16-byte aligned");

  sequence s_fault_seen;
    state == ST_CHK && fault;
  endsequence
  property p_no_store;
    s_fault_seen |=> state == ST_IDLE && !mem_req.valid && gp_f;
  endproperty
  a_no_store: assert property (p_no_store) else $error("store after gate fault");

  property p_null_ec;
    (state == ST_CHK && !fault && (!event_r[E_SEGREF] || event_r[E_NULL])) |=> errcode == RST_ZERO;
  endproperty
  a_null_ec: assert property (p_null_ec) else $error("null error code not zero");

  property p_quiet;
    (state == ST_PUSH && mem_req.we && idx == 3'd5) |-> !quiet && event_r[E_HASEC];
  endproperty
  a_quiet: assert property (p_quiet) else $error("error code pushed for quiet source");

  property p_ss_null;
    (state == ST_PUSH && idx == 3'd6 && m64 && cpl_chg) |=> ss_sel[15:2] == 14'h0 && ss_sel[1:0] == $past(tgt_cpl);
  endproperty
  a_ss_null: assert property (p_ss_null) else $error("new stack selector not null");

  property p_gp16;
    (state == ST_CHK && long_mode_active && (gtype == GT_INT16 || gtype == GT_TRAP16)) |=> gp_f && errcode == RST_ZERO;
  endproperty
  a_gp16: assert property (p_gp16) else $error("16-bit gate did not fault with zero");

  property p_cs64;
    (state == ST_CHK && long_mode_active && gtype == GT_INT && canon && ctrl[C_CSD]) |=> gp_f && errcode[10:3] == $past(vec);
  endproperty
  a_cs64: assert property (p_cs64) else $error("bad code segment fault code");

  property p_null_ok;
    (state == ST_RCHK && pops && pop_ss[15:2] == 14'h0 && ctrl[C_CSL] && pop_cs[1:0] != 2'h3) |=> !gp_f && !ssld_f;
  endproperty
  a_null_ok: assert property (p_null_ok) else $error("null stack selector refused");

  property p_pop_cnt;
    (state == ST_POP && idx == 3'd5 && m64) |-> ptr == sp + 64'(5 * popw);
  endproperty
  a_pop_cnt: assert property (p_pop_cnt) else $error("return did not pop five items");

endmodule : eec_unit

/* File: eec_unit_note_end.sv */
// Intentionally empty
`timescale 1ns/100ps

/* File: eec_unit_tb.sv */
// Self-checking testbench of the exception entry and return unit
`timescale 1ns/100ps
module eec_unit_tb
  import eec_pkg::*;
;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic s_awvalid = 1'b0;
  logic s_wvalid = 1'b0;
  logic s_bready = 1'b0;
  logic s_arvalid = 1'b0;
  logic s_rready = 1'b0;
  logic slow = 1'b0;
  logic [7:0] s_awaddr = 8'h00;
  logic [7:0] s_araddr = 8'h00;
  logic [31:0] s_wdata = 32'h0;
  logic [3:0] s_wstrb = 4'hF;
  logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid, mem_ready;
  logic [1:0] s_bresp, s_rresp;
  logic [31:0] s_rdata;
  logic [63:0] mem_rdata;
  eec_mem_req_s mem_req;
  int fails = 0;
  int total_checks = 0;
  eec_unit eec_unit_i (.aclk, .aresetn, .s_awaddr, .s_awvalid, .s_awready, .s_wdata, .s_wstrb, .s_wvalid,
    .s_wready, .s_bresp, .s_bvalid, .s_bready, .s_araddr, .s_arvalid, .s_arready, .s_rdata, .s_rresp,
    .s_rvalid, .s_rready, .mem_req, .mem_ready, .mem_rdata);
  eec_mem_model eec_mem_model_i (.aclk, .slow, .mem_req, .mem_ready, .mem_rdata);
  initial begin
    forever #5 aclk = !aclk;
  end
  //==========================================================
  // Bus and check tasks
  task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic test_done;
    $display("checks %0d fails %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : test_done
  task automatic tmo;
    chk("timeout", 64'h0, 64'h1);
    test_done();
  endtask : tmo
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge aclk);
    s_awaddr <= a;
    s_wdata <= d;
    s_awvalid <= 1'b1;
    s_wvalid <= 1'b1;
    s_bready <= 1'b1;
    for (k = 0; k < 100; k++) begin
      @(posedge aclk);
      if (s_awready) s_awvalid <= 1'b0;
      if (s_wready) s_wvalid <= 1'b0;
      if (s_bvalid) break;
    end
    if (k < 100) chk("bresp", s_bresp, RESP_OKAY);
    s_bready <= 1'b0;
    if (k == 100) tmo();
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int k;
    @(posedge aclk);
    s_araddr <= a;
    s_arvalid <= 1'b1;
    s_rready <= 1'b1;
    for (k = 0; k < 100; k++) begin
      @(posedge aclk);
      if (s_arready) s_arvalid <= 1'b0;
      if (s_rvalid) break;
    end
    d = s_rdata;
    r = s_rresp;
    s_rready <= 1'b0;
    if (k == 100) tmo();
  endtask : rd
  task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    chk(nm, d, e);
  endtask : rchk
  task automatic sbit(input string nm, input int b, input logic e);
    logic [31:0] d;
    logic [1:0] r;
    rd(OFF_STATUS, d, r);
    chk(nm, d[b], e);
  endtask : sbit
  task automatic setup(input logic [31:0] sp, input logic [31:0] ev);
    wr(OFF_IDT, 32'h100);
    wr(OFF_SP_LO, sp);
    wr(OFF_SEL, 32'h0010_0018);
    wr(OFF_FLAGS, 32'h202);
    wr(OFF_IP_LO, 32'h4000);
    wr(OFF_TSP_LO, 32'h180);
    wr(OFF_EVENT, ev);
  endtask : setup
  task automatic go(input logic [31:0] c);
    logic [31:0] d;
    logic [1:0] r;
    int k;
    eec_mem_model_i.n = 0;
    wr(OFF_CTRL, c);
    for (k = 0; k < 100; k++) begin
      rd(OFF_STATUS, d, r);
      if (d[S_BUSY] === 1'b0) break;
    end
    if (k == 100) tmo();
  endtask : go
  //==========================================================
  // Scenarios
  task automatic t_reset;
    logic [31:0] d;
    logic [1:0] r;
    rchk("ctrl", OFF_CTRL, 32'h0);
    rchk("status", OFF_STATUS, 32'h0);
    rd(8'h3C, d, r);
    chk("unmapped", r, RESP_DECERR);
  endtask : t_reset
  task automatic t_deliver;
    logic [63:0] e [6] = '{64'h18, 64'h1FC, 64'h202, 64'h10, 64'h4000, 64'h2B};
    int i;
    eec_mem_model_i.mem[6'h26] = 64'h1234_8E02_0008_5678;
    eec_mem_model_i.mem[6'h27] = 64'h0;
    setup(32'h1FC, 32'h0005_5903);
    go(32'h0000_010D);
    chk("count", eec_mem_model_i.n, 8);
    chk("gate", eec_mem_model_i.log_addr[0], 64'h130);
    chk("gate hi", eec_mem_model_i.log_addr[1], 64'h138);
    for (i = 0; i < 6; i++) begin
      chk("push addr", eec_mem_model_i.log_addr[i + 2], 64'h1E8 - 8 * i);
      chk("push data", eec_mem_model_i.log_data[i + 2], e[i]);
      chk("push size", eec_mem_model_i.log_bytes[i + 2], SLOT64);
    end
    rchk("code", OFF_ERRCODE, 32'h2B);
    rchk("status", OFF_STATUS, 32'h000E_0202);
  endtask : t_deliver
  task automatic t_codes;
    logic [31:0] ev [3] = '{32'h0005_3803, 32'h0005_B803, 32'h0005_1803};
    logic [31:0] ec [3] = '{32'h2C, 32'h0, 32'h28};
    int i;
    for (i = 0; i < 3; i++) begin
      setup(32'h1FC, ev[i]);
      go(32'h0000_010D);
      rchk("code", OFF_ERRCODE, ec[i]);
    end
  endtask : t_codes
  task automatic t_pin;
    slow <= 1'b1;
    setup(32'h1FC, 32'h0005_5A03);
    go(32'h0000_013D);
    chk("pin count", eec_mem_model_i.n, 7);
    chk("inner top", eec_mem_model_i.log_addr[2], 64'h178);
    chk("old ss", eec_mem_model_i.log_data[2], 64'h18);
    chk("old sp", eec_mem_model_i.log_data[3], 64'h1FC);
    slow <= 1'b0;
  endtask : t_pin
  task automatic t_fault;
    logic [63:0] g0 [5] = '{64'h1234_8602_0008_5678, 64'h1234_8702_0008_5678, 64'h1234_8E02_0008_5678,
      64'h1234_8E02_0008_5678, 64'h1234_8F02_0008_5678};
    logic [63:0] g1 [5] = '{64'h0, 64'h0, 64'h0000_8000, 64'h0, 64'h0};
    logic [31:0] c [5] = '{32'h10D, 32'h10D, 32'h10D, 32'h30D, 32'h10D};
    logic gp [5] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0};
    int i;
    for (i = 0; i < 5; i++) begin
      eec_mem_model_i.mem[6'h26] = g0[i];
      eec_mem_model_i.mem[6'h27] = g1[i];
      setup(32'h1FC, 32'h0005_5903);
      go(c[i]);
      sbit("gp", S_GP, gp[i]);
      chk("accesses", eec_mem_model_i.n, gp[i] ? 2 : 8);
      if (i < 2) rchk("gp code", OFF_ERRCODE, 32'h0);
      if (i == 3) rchk("vec code", OFF_ERRCODE, 32'h1B);
    end
  endtask : t_fault
  task automatic t_legacy;
    // Legacy 32-bit gate: 8-byte entry, 4-byte pushes, no stack pointer push, no alignment
    eec_mem_model_i.mem[6'h23] = 64'h0000_8E00_0008_5678;
    setup(32'h1FC, 32'h0005_5903);
    go(32'h0000_0001);
    chk("legacy count", eec_mem_model_i.n, 5);
    chk("legacy gate", eec_mem_model_i.log_addr[0], 64'h118);
    chk("legacy top", eec_mem_model_i.log_addr[1], 64'h1F8);
    chk("legacy size", eec_mem_model_i.log_bytes[4], SLOT32);
  endtask : t_legacy
  task automatic t_return;
    // Handler software steps past the error code before returning
    wr(OFF_SP_LO, 32'h1C8);
    go(32'h0000_0C0E);
    chk("pops", eec_mem_model_i.n, 5);
    chk("pop first", eec_mem_model_i.log_addr[0], 64'h1C8);
    chk("pop last", eec_mem_model_i.log_addr[4], 64'h1E8);
    rchk("sp back", OFF_SP_LO, 32'h1FC);
    sbit("ss load", S_SSLD, 1'b1);
    eec_mem_model_i.mem[6'h3D] = 64'h0;
    wr(OFF_SP_LO, 32'h1C8);
    // Target code segment is 64-bit, so a null stack selector is legal
    go(32'h0000_0D0E);
    sbit("null ss", S_SSLD, 1'b0);
    sbit("null gp", S_GP, 1'b0);
  endtask : t_return
  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_deliver();
    t_codes();
    t_pin();
    t_legacy();
    t_fault();
    t_return();
    test_done();
  end
endmodule : eec_unit_tb
